// File: ddc_slice_ctrl.sv
// dsp slice dynamic control with register bus and pipeline
//
// Decided for this implementation: the placing of the registers and the AXI4-Lite slave port.
`timescale 1ns/1ps
`default_nettype none
// How it works
// - one sign bit sets operand a format, the other operand b
// - sign bits select signed or unsigned for each multiplier operand
// - first-stage round enable rounds the product plus feedback, else passes it
// - second-stage round enable rounds the chain-out value, else passes it
// - first-stage saturate enable clamps the result in q-format
// - second-stage saturate enable clamps the chain-out value in q-format
// - with both enabled, the rounded value is saturated
// - zero-load forces accumulator feedback to zero, else feedback from outputs
// - chain zeroing replaces the incoming cascade value by zero
// - loopback zeroing forces the feedback value to zero
// - rotate control rotates the 32-bit shift operand
// - right select shifts right; neither select gives a left shift
// - four register groups each have their own update gate
// - four active-low clears empty their groups without a clock edge
// - arithmetic right shift fills vacated bits with the sign
// - symmetric saturation minimum sits one step above two's minimum
// - rounding point lies in bits 15..0, saturation in 43..31
// - nearest-even adds on a tie only when the kept lsb is odd
module ddc_slice_ctrl import ddc_pkg::*; (
    // clock, reset, enable
    input  wire logic        CORE_CLK,
    input  wire logic        RESET,
    input  wire logic        CE,
    // write address and data
    input  wire logic [7:0]  AWADDR,
    input  wire logic        AWVALID,
    output logic             AWREADY,
    input  wire logic [31:0] WDATA,
    input  wire logic [3:0]  WSTRB,
    input  wire logic        WVALID,
    output logic             WREADY,
    // write response
    output logic [1:0]       BRESP,
    output logic             BVALID,
    input  wire logic        BREADY,
    // read address and data
    input  wire logic [7:0]  ARADDR,
    input  wire logic        ARVALID,
    output logic             ARREADY,
    output logic [31:0]      RDATA,
    output logic [1:0]       RRESP,
    output logic             RVALID,
    input  wire logic        RREADY
);
    typedef struct packed {
        logic              awready;
        logic              wready;
        logic              bvalid;
        logic [1:0]        bresp;
        logic              arready;
        logic              rvalid;
        logic [1:0]        rresp;
        logic [31:0]       rdata;
        logic [CTRL_W-1:0] ctrl;
        logic [31:0]       opa;
        logic [31:0]       opb;
        logic [31:0]       chain;
        logic [NGRP-1:0]   gate;
        logic [NGRP-1:0]   clr_n;
        logic              go;
        logic              st1;
        logic              st2;
        logic              st3;
    } ddc_state_t;

    ddc_state_t s;
    ddc_state_t next_s;

    logic [GRP_W-1:0] grp_d [NGRP];
    logic [GRP_W-1:0] grp_q [NGRP];
    logic [NGRP-1:0]  grp_en;

    logic [31:0]             a_opa;
    logic [31:0]             a_opb;
    logic [CTRL_W-1:0]       a_ctrl;
    logic [31:0]             a_chain;
    logic [ACC_W-1:0]        b_prod;
    logic [31:0]             b_shift;
    logic [ACC_W-1:0]        c_acc;
    logic                    c_ovf;
    logic [ACC_W-1:0]        d_chain;
    logic                    d_ovf;
    logic signed [MUL_W:0]   mul_a;
    logic signed [MUL_W:0]   mul_b;
    logic signed [2*MUL_W+1:0] prod;
    logic [31:0]             shift;
    logic [63:0]             rot2;
    logic [4:0]              amt;
    logic [ACC_W-1:0]        fb;
    logic [ACC_W-1:0]        cin;
    logic [ACC_W-1:0]        sum1;
    logic [ACC_W-1:0]        sum2;
    logic [ACC_W-1:0]        rs1;
    logic [ACC_W-1:0]        rs2;
    logic                    ovf1;
    logic                    ovf2;
    logic                    busy;

    function automatic logic [31:0] merge(input logic [31:0] old,
                                          input logic [31:0] nw,
                                          input logic [3:0]  be);
        logic [31:0] r;
        r = old;
        for (int i = 0; i < 4; i++) begin
            if (be[i]) begin
                r[8*i +: 8] = nw[8*i +: 8];
            end
        end
        return r;
    endfunction

    // =========================================================
    // group fields
    assign a_opa   = grp_q[0][106:75];
    assign a_opb   = grp_q[0][74:43];
    assign a_ctrl  = grp_q[0][42:32];
    assign a_chain = grp_q[0][31:0];
    assign b_prod  = grp_q[1][43:0];
    assign b_shift = grp_q[1][75:44];
    assign c_acc   = grp_q[2][43:0];
    assign c_ovf   = grp_q[2][44];
    assign d_chain = grp_q[3][43:0];
    assign d_ovf   = grp_q[3][44];
    assign busy    = s.go | s.st1 | s.st2 | s.st3;
    assign amt     = a_opb[4:0];

    // =========================================================
    // datapath
    always_comb begin
        mul_a = {a_ctrl[C_SIGNA] & a_opa[17], a_opa[17:0]};
        mul_b = {a_ctrl[C_SIGNB] & a_opb[17], a_opb[17:0]};
        prod  = mul_a * mul_b;
        rot2  = {a_opa, a_opa} << amt;
        if (a_ctrl[C_ROT]) begin
            shift = rot2[63:32];
        end else if (a_ctrl[C_SHR] && a_ctrl[C_SIGNA]) begin
            shift = $signed(a_opa) >>> amt;
        end else if (a_ctrl[C_SHR]) begin
            shift = a_opa >> amt;
        end else begin
            shift = a_opa << amt;
        end
        fb = (a_ctrl[C_SLOAD] || a_ctrl[C_ZLOOP]) ? '0 : c_acc;
        cin = a_ctrl[C_ZCHAIN] ? '0 : {{12{a_chain[31]}}, a_chain};
        sum1 = b_prod + fb;
        sum2 = c_acc + cin;
        grp_d[0] = {1'b0, s.opa, s.opb, s.ctrl, s.chain};
        grp_d[1] = {32'h00000000, shift, {{6{prod[37]}}, prod}};
        grp_d[2] = {63'h0, ovf1, rs1};
        grp_d[3] = {63'h0, ovf2, rs2};
        grp_en = {s.st3 & s.gate[3], s.st2 & s.gate[2],
                  s.st1 & s.gate[1], s.go & s.gate[0]};
    end

    // rounding and saturation points are fixed in the package
    ddc_round_sat u_rs1 (
        .din    (sum1),
        .rnd_en (a_ctrl[C_ORND]),
        .sat_en (a_ctrl[C_OSAT]),
        .dout   (rs1),
        .ovf    (ovf1)
    );

    ddc_round_sat u_rs2 (
        .din    (sum2),
        .rnd_en (a_ctrl[C_CRND]),
        .sat_en (a_ctrl[C_CSAT]),
        .dout   (rs2),
        .ovf    (ovf2)
    );

    for (genvar g = 0; g < NGRP; g++) begin : g_grp
        ddc_grp_reg u_grp (
            .clk   (CORE_CLK),
            .rst   (RESET),
            .ce    (CE),
            .en    (grp_en[g]),
            .clr_n (s.clr_n[g]),
            .d     (grp_d[g]),
            .q     (grp_q[g])
        );
    end

    // =========================================================
    // register bus
    always_comb begin
        next_s = s;
        next_s.awready = 1'b0;
        next_s.wready  = 1'b0;
        next_s.arready = 1'b0;
        next_s.go      = 1'b0;
        next_s.st1     = s.go;
        next_s.st2     = s.st1;
        next_s.st3     = s.st2;
        if (s.bvalid && BREADY) begin
            next_s.bvalid = 1'b0;
        end
        if (s.awready) begin
            next_s.bvalid = 1'b1;
        end
        if (!s.bvalid && !s.awready && AWVALID && WVALID) begin
            next_s.awready = 1'b1;
            next_s.wready  = 1'b1;
            next_s.bresp   = RESP_OK;
            case (AWADDR)
                OFF_CTRL: begin
                    next_s.ctrl = CTRL_W'(merge(32'(s.ctrl), WDATA, WSTRB));
                end
                OFF_OPA: begin
                    next_s.opa = merge(s.opa, WDATA, WSTRB);
                end
                OFF_OPB: begin
                    next_s.opb = merge(s.opb, WDATA, WSTRB);
                end
                OFF_CHAIN: begin
                    next_s.chain = merge(s.chain, WDATA, WSTRB);
                end
                OFF_GATE: begin
                    if (WSTRB[0]) next_s.gate = WDATA[3:0];
                end
                OFF_CLEAR: begin
                    if (WSTRB[0]) next_s.clr_n = WDATA[3:0];
                end
                OFF_GO: begin
                    next_s.go = WSTRB[0] & WDATA[0];
                end
                OFF_STATUS, OFF_ACC_LO, OFF_ACC_HI, OFF_CHOUT_LO,
                OFF_CHOUT_HI, OFF_SHIFT: begin
                    next_s.bresp = RESP_OK;
                end
                default: begin
                    next_s.bresp = RESP_ERR;
                end
            endcase
        end
        if (s.rvalid && RREADY) begin
            next_s.rvalid = 1'b0;
        end
        if (s.arready) begin
            next_s.rvalid = 1'b1;
        end
        if (!s.rvalid && !s.arready && ARVALID) begin
            next_s.arready = 1'b1;
            next_s.rresp   = RESP_OK;
            case (ARADDR)
                OFF_CTRL:     next_s.rdata = 32'(s.ctrl);
                OFF_OPA:      next_s.rdata = s.opa;
                OFF_OPB:      next_s.rdata = s.opb;
                OFF_CHAIN:    next_s.rdata = s.chain;
                OFF_GATE:     next_s.rdata = 32'(s.gate);
                OFF_CLEAR:    next_s.rdata = 32'(s.clr_n);
                OFF_GO:       next_s.rdata = 32'h00000000;
                OFF_STATUS:   next_s.rdata = {29'h0, d_ovf, c_ovf, busy};
                OFF_ACC_LO:   next_s.rdata = c_acc[31:0];
                OFF_ACC_HI:   next_s.rdata = {20'h0, c_acc[43:32]};
                OFF_CHOUT_LO: next_s.rdata = d_chain[31:0];
                OFF_CHOUT_HI: next_s.rdata = {20'h0, d_chain[43:32]};
                OFF_SHIFT:    next_s.rdata = b_shift;
                default: begin
                    next_s.rdata = 32'h00000000;
                    next_s.rresp = RESP_ERR;
                end
            endcase
        end
        if (!CE) begin
            next_s = s;
        end
    end

    always_ff @(posedge CORE_CLK) begin
        if (RESET) begin
            s       <= '0;
            s.gate  <= RST_GATE;
            s.clr_n <= RST_CLEAR;
        end else begin
            s <= next_s;
        end
    end

    assign AWREADY = s.awready;
    assign WREADY  = s.wready;
    assign BVALID  = s.bvalid;
    assign BRESP   = s.bresp;
    assign ARREADY = s.arready;
    assign RVALID  = s.rvalid;
    assign RRESP   = s.rresp;
    assign RDATA   = s.rdata;

    // =========================================================
    // assertions
    default clocking cb @(posedge CORE_CLK);
    endclocking
    default disable iff (RESET);

    logic b_load;
    logic c_load;
    logic d_load;
    assign b_load = CE && grp_en[1] && s.clr_n[1];
    assign c_load = CE && grp_en[2] && s.clr_n[2];
    assign d_load = CE && grp_en[3] && s.clr_n[3];

    mult_sign_a: assert property (b_load && a_ctrl[C_SIGNA] && a_opa[17]
        && a_opb[17:0] == 18'h00001 |=> b_prod[ACC_W-1])
        else $error("signed multiplicand lost its sign");
    round_off_a: assert property (c_load && !a_ctrl[C_ORND]
        && !a_ctrl[C_OSAT] && a_ctrl[C_SLOAD] |=> c_acc == $past(b_prod))
        else $error("unrounded first stage altered the product");
    sat_range_a: assert property (c_load && a_ctrl[C_OSAT] |=>
        c_acc[ACC_W-1:SAT_POS] == {(ACC_W-SAT_POS){c_acc[ACC_W-1]}})
        else $error("first stage left the saturation range");
    sym_min_a: assert property (d_load && a_ctrl[C_CSAT]
        && !a_ctrl[C_CRND] && ovf2 && sum2[ACC_W-1] |=>
        d_chain[31:0] == 32'h80000001)
        else $error("symmetric minimum wrong");
    chain_zero_a: assert property (d_load && a_ctrl[C_ZCHAIN]
        && !a_ctrl[C_CRND] && !a_ctrl[C_CSAT] |=> d_chain == $past(c_acc))
        else $error("zeroed chain input still added");
    shift_left_a: assert property (b_load && !a_ctrl[C_ROT]
        && !a_ctrl[C_SHR] |=> b_shift == $past(a_opa << amt))
        else $error("left shift wrong");
    asr_fill_a: assert property (b_load && a_ctrl[C_SHR] && !a_ctrl[C_ROT]
        && a_ctrl[C_SIGNA] && a_opa[31] |=> b_shift[31])
        else $error("arithmetic right shift lost sign fill");
    gate_hold_a: assert property (!s.gate[2] && s.clr_n[2]
        |=> !s.clr_n[2] || $stable(c_acc))
        else $error("gated accumulator changed");
    clear_grp_a: assert property (!s.clr_n[2] && $past(!s.clr_n[2])
        |-> c_acc == '0)
        else $error("cleared group not empty");
    bus_resp_a: assert property (AWREADY && AWVALID |=> BVALID)
        else $error("write response missing");

    go_c: cover property (s.go ##3 s.st3);
    ovf_c: cover property (d_load && ovf2);
    rot_c: cover property (b_load && a_ctrl[C_ROT]);
    rd_c: cover property (RVALID && RREADY);
endmodule
`default_nettype wire

// File: ddc_pkg.sv
// constants and field layout for the dsp dynamic control block
package ddc_pkg;
    localparam int ACC_W  = 44;
    localparam int MUL_W  = 18;
    localparam int SH_W   = 32;
    localparam int GRP_W  = 108;
    localparam int NGRP   = 4;
    localparam int CTRL_W = 11;
    // register byte offsets
    localparam logic [7:0] OFF_CTRL     = 8'h00;
    localparam logic [7:0] OFF_OPA      = 8'h04;
    localparam logic [7:0] OFF_OPB      = 8'h08;
    localparam logic [7:0] OFF_CHAIN    = 8'h0C;
    localparam logic [7:0] OFF_GATE     = 8'h10;
    localparam logic [7:0] OFF_CLEAR    = 8'h14;
    localparam logic [7:0] OFF_GO       = 8'h18;
    localparam logic [7:0] OFF_STATUS   = 8'h1C;
    localparam logic [7:0] OFF_ACC_LO   = 8'h20;
    localparam logic [7:0] OFF_ACC_HI   = 8'h24;
    localparam logic [7:0] OFF_CHOUT_LO = 8'h28;
    localparam logic [7:0] OFF_CHOUT_HI = 8'h2C;
    localparam logic [7:0] OFF_SHIFT    = 8'h30;
    // control field positions
    localparam int C_SIGNA  = 0;
    localparam int C_SIGNB  = 1;
    localparam int C_ORND   = 2;
    localparam int C_CRND   = 3;
    localparam int C_OSAT   = 4;
    localparam int C_CSAT   = 5;
    localparam int C_SLOAD  = 6;
    localparam int C_ZCHAIN = 7;
    localparam int C_ZLOOP  = 8;
    localparam int C_ROT    = 9;
    localparam int C_SHR    = 10;
    // status field positions
    localparam int S_BUSY = 0;
    localparam int S_OVF1 = 1;
    localparam int S_OVF2 = 2;
    // reset values
    localparam logic [NGRP-1:0] RST_GATE  = 4'hF;
    localparam logic [NGRP-1:0] RST_CLEAR = 4'hF;
    // compile-time round and saturate settings
    localparam int RND_POS  = 16;
    localparam int SAT_POS  = 31;
    localparam bit RND_EVEN = 1'b0;
    localparam bit SAT_SYM  = 1'b1;
    localparam logic [1:0] RESP_OK  = 2'h0;
    localparam logic [1:0] RESP_ERR = 2'h2;
endpackage

// File: ddc_round_sat.sv
// round then saturate stage, combinational
`timescale 1ns/1ps
`default_nettype none
module ddc_round_sat import ddc_pkg::*; (
    // value
    input  wire logic [ACC_W-1:0] din,
    // stage controls
    input  wire logic             rnd_en,
    input  wire logic             sat_en,
    // result
    output logic      [ACC_W-1:0] dout,
    output logic                  ovf
);
    localparam logic [ACC_W-1:0] ONE   = 44'h00000000001;
    localparam logic [ACC_W-1:0] HALF  = ONE << (RND_POS - 1);
    localparam logic [ACC_W-1:0] RMASK = (ONE << RND_POS) - ONE;
    localparam logic [ACC_W-1:0] SMAX  = (ONE << SAT_POS) - ONE;
    localparam logic [ACC_W-1:0] SMIN  = ~SMAX;

    logic [ACC_W-1:0] res;
    logic [ACC_W-1:0] rnd;
    logic [ACC_W-1:0] step;

    always_comb begin
        res  = din & RMASK;
        step = rnd_en ? (ONE << RND_POS) : ONE;
        if (!rnd_en) begin
            rnd = din;
        end else if (RND_EVEN && res == HALF && !din[RND_POS]) begin
            rnd = din & ~RMASK;
        end else begin
            rnd = (din + HALF) & ~RMASK;
        end
        // saturation looks at the rounded value
        ovf = sat_en && (rnd[ACC_W-1:SAT_POS] !=
              {(ACC_W-SAT_POS){rnd[ACC_W-1]}});
        if (!ovf) begin
            dout = rnd;
        end else if (rnd[ACC_W-1]) begin
            dout = SAT_SYM ? SMIN + step : SMIN;
        end else begin
            dout = SMAX;
        end
    end
endmodule
`default_nettype wire

// File: ddc_grp_reg.sv
// one register group with update gate and asynchronous clear
`timescale 1ns/1ps
`default_nettype none
module ddc_grp_reg import ddc_pkg::*; (
    // clocking
    input  wire logic             clk,
    input  wire logic             rst,
    input  wire logic             ce,
    // group controls
    input  wire logic             en,
    input  wire logic             clr_n,
    // data
    input  wire logic [GRP_W-1:0] d,
    output logic      [GRP_W-1:0] q
);
    typedef struct packed {
        logic [GRP_W-1:0] q;
    } ddc_grp_t;

    ddc_grp_t st;
    ddc_grp_t next_st;

    always_comb begin
        next_st = st;
        if (ce && en) begin
            next_st.q = d;
        end
    end

    always_ff @(posedge clk or negedge clr_n) begin
        if (!clr_n) begin
            st <= '0;
        end else if (rst) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign q = st.q;
endmodule
`default_nettype wire

// File: ddc_fab_model.sv
// fabric-side bus master model for the slice control registers
`timescale 1ns/1ps
`default_nettype none
module ddc_fab_model (
    // clocking
    input  wire logic        clk,
    input  wire logic        rst,
    // bench command
    input  wire logic        cmd_go,
    input  wire logic        cmd_wr,
    input  wire logic [7:0]  cmd_addr,
    input  wire logic [31:0] cmd_data,
    output logic             done,
    output logic [31:0]      rd_data,
    output logic [1:0]       rd_resp,
    // register bus
    output logic [7:0]       awaddr,
    output logic             awvalid,
    input  wire logic        awready,
    output logic [31:0]      wdata,
    output logic [3:0]       wstrb,
    output logic             wvalid,
    input  wire logic        wready,
    input  wire logic [1:0]  bresp,
    input  wire logic        bvalid,
    output logic             bready,
    output logic [7:0]       araddr,
    output logic             arvalid,
    input  wire logic        arready,
    input  wire logic [31:0] rdata,
    input  wire logic [1:0]  rresp,
    input  wire logic        rvalid,
    output logic             rready
);
    assign wstrb = 4'hF;
    // each command is one register access; controls change between ops
    always @(posedge clk) begin
        done <= 1'b0;
        if (rst) begin
            {awvalid, wvalid, arvalid, bready, rready} <= 5'h00;
        end else begin
            if (cmd_go && cmd_wr) begin
                {awvalid, wvalid, bready} <= 3'h7;
                awaddr <= cmd_addr;
                wdata <= cmd_data;
            end
            if (cmd_go && !cmd_wr) begin
                {arvalid, rready} <= 2'h3;
                araddr <= cmd_addr;
            end
            // released lines show the inverse of the last value
            if (awvalid && awready) begin
                awvalid <= 1'b0;
                awaddr <= ~awaddr;
            end
            if (wvalid && wready) begin
                wvalid <= 1'b0;
                wdata <= ~wdata;
            end
            if (arvalid && arready) begin
                arvalid <= 1'b0;
                araddr <= ~araddr;
            end
            if (bready && bvalid) begin
                bready <= 1'b0;
                rd_resp <= bresp;
                done <= 1'b1;
            end
            if (rready && rvalid) begin
                rready <= 1'b0;
                rd_data <= rdata;
                rd_resp <= rresp;
                done <= 1'b1;
            end
        end
    end
endmodule
`default_nettype wire

// File: tb.sv
// self-checking bench for the slice dynamic control block
`timescale 1ns/1ps
`default_nettype none
module tb import ddc_pkg::*; ;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic go = 1'b0;
    logic wr = 1'b0;
    logic [7:0] ad = 8'h00;
    logic [31:0] wd = 32'h0;
    logic done, awv, awr, wv, wrd, bv, br, arv, arr, rv, rr;
    logic [31:0] rdd, wda, rda, a, b, ch, c, st, shv;
    logic [1:0] rsp, bre, rre;
    logic [7:0] awa, ara;
    logic [3:0] wst;
    logic [43:0] acc, cho, p, e;
    logic [31:0] seed = 32'h5BFE2C0C;
    int error_cnt = 0;
    int samples_checked = 0;
    ddc_slice_ctrl dut (.CORE_CLK(clk), .RESET(rst), .CE(1'b1),
        .AWADDR(awa), .AWVALID(awv), .AWREADY(awr), .WDATA(wda),
        .WSTRB(wst), .WVALID(wv), .WREADY(wrd), .BRESP(bre), .BVALID(bv),
        .BREADY(br), .ARADDR(ara), .ARVALID(arv), .ARREADY(arr),
        .RDATA(rda), .RRESP(rre), .RVALID(rv), .RREADY(rr));
    ddc_fab_model fab (.clk(clk), .rst(rst), .cmd_go(go), .cmd_wr(wr),
        .cmd_addr(ad), .cmd_data(wd), .done(done), .rd_data(rdd),
        .rd_resp(rsp), .awaddr(awa), .awvalid(awv), .awready(awr),
        .wdata(wda), .wstrb(wst), .wvalid(wv), .wready(wrd), .bresp(bre),
        .bvalid(bv), .bready(br), .araddr(ara), .arvalid(arv),
        .arready(arr), .rdata(rda), .rresp(rre), .rvalid(rv), .rready(rr));
    initial begin
        forever #4 clk = ~clk;
    end
    // ==========================================
    // expectations
    function automatic logic [31:0] rnd32();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction
    function automatic logic [43:0] mul_x(input logic [31:0] x,
        input logic [31:0] y, input logic sx, input logic sy);
        logic [43:0] ex;
        logic [43:0] ey;
        ex = {{26{sx & x[17]}}, x[17:0]};
        ey = {{26{sy & y[17]}}, y[17:0]};
        return ex * ey;
    endfunction
    function automatic logic [43:0] rs_x(input logic [43:0] v,
        input logic rn, input logic sat);
        logic [43:0] r;
        r = rn ? ((v + 44'h00000008000) & 44'hFFFFFFF0000) : v;
        if (sat && !r[43] && r[42:31] != 12'h000) r = 44'h0007FFFFFFF;
        if (sat && r[43] && r[42:31] != 12'hFFF) r = 44'hFFF80000001;
        return r;
    endfunction
    function automatic logic [31:0] sh_x(input logic [31:0] x,
        input logic [4:0] n, input logic rot, input logic shr, input logic sx);
        if (rot) return (x << n) | (x >> (6'd32 - n));
        if (shr && sx) return $signed(x) >>> n;
        if (shr) return x >> n;
        return x << n;
    endfunction
    // ==========================================
    // tasks
    task automatic print_verdict();
        $display("errors %0d checks %0d", error_cnt, samples_checked);
        if (error_cnt == 0 && samples_checked > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    task automatic chk(input logic [43:0] got, input logic [43:0] exp);
        samples_checked++;
        if (got !== exp) begin
            error_cnt++;
            $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic xfer(input logic w, input logic [7:0] x,
        input logic [31:0] d);
        int n = 0;
        @(posedge clk);
        go <= 1'b1;
        wr <= w;
        ad <= x;
        wd <= d;
        @(posedge clk);
        go <= 1'b0;
        do begin
            @(posedge clk);
            #1;
            n++;
        end while (done !== 1'b1 && n < 100);
        if (done !== 1'b1) begin
            error_cnt++;
            $display("MISMATCH t=%0t bus timeout", $time);
            print_verdict();
        end
    endtask
    task automatic run_op(input logic [31:0] z);
        int n = 0;
        xfer(1'b1, OFF_CTRL, c);
        xfer(1'b1, OFF_OPA, a);
        xfer(1'b1, OFF_OPB, b);
        xfer(1'b1, OFF_CHAIN, z);
        xfer(1'b1, OFF_GO, 32'h1);
        do begin
            xfer(1'b0, OFF_STATUS, 32'h0);
            n++;
        end while (rdd[S_BUSY] !== 1'b0 && n < 20);
        st = rdd;
        chk(44'(st[S_BUSY]), 44'h0);
        xfer(1'b0, OFF_ACC_LO, 32'h0);
        acc[31:0] = rdd;
        xfer(1'b0, OFF_ACC_HI, 32'h0);
        acc[43:32] = rdd[11:0];
        xfer(1'b0, OFF_CHOUT_LO, 32'h0);
        cho[31:0] = rdd;
        xfer(1'b0, OFF_CHOUT_HI, 32'h0);
        cho[43:32] = rdd[11:0];
        xfer(1'b0, OFF_SHIFT, 32'h0);
        shv = rdd;
    endtask
    // ==========================================
    // main sequence
    initial begin
        repeat (12) @(posedge clk);
        rst <= 1'b0;
        xfer(1'b0, OFF_GATE, 32'h0);
        chk(44'(rdd), 44'(RST_GATE));
        xfer(1'b0, OFF_CLEAR, 32'h0);
        chk(44'(rdd), 44'(RST_CLEAR));
        xfer(1'b0, 8'h40, 32'h0);
        chk({rdd, 10'h0, rsp}, {32'h0, 10'h0, RESP_ERR});
        xfer(1'b1, 8'h40, rnd32());
        chk(44'(rsp), 44'(RESP_ERR));
        // sign modes and shift modes, random operands
        for (int k = 0; k < 12; k++) begin
            a = rnd32();
            b = rnd32();
            if (k == 4) b[4:0] = 5'h1F;
            if (k == 5) a[31] = 1'b1;
            if (k == 8) b[4:0] = 5'h00;
            c = 32'h0;
            c[C_SIGNA] = k[0];
            c[C_SIGNB] = k[1];
            c[C_SLOAD] = 1'b1;
            c[C_ZCHAIN] = 1'b1;
            c[C_SHR] = (k / 4 == 1);
            c[C_ROT] = (k / 4 == 2);
            run_op(rnd32());
            p = mul_x(a, b, k[0], k[1]);
            chk(acc, p);
            chk(cho, p);
            chk(44'(shv), 44'(sh_x(a, b[4:0], c[C_ROT], c[C_SHR], k[0])));
        end
        // rounding in both stages, tie case last
        for (int k = 0; k < 4; k++) begin
            a = (k == 3) ? 32'h1 : rnd32();
            b = (k == 3) ? 32'h8000 : rnd32();
            ch = rnd32();
            c = 32'h0;
            c[C_SIGNA] = 1'b1;
            c[C_SIGNB] = 1'b1;
            c[C_SLOAD] = 1'b1;
            c[C_ORND] = k[0];
            c[C_CRND] = 1'b1;
            run_op(ch);
            e = rs_x(mul_x(a, b, 1'b1, 1'b1), k[0], 1'b0);
            chk(acc, e);
            chk(cho, rs_x(e + {{12{ch[31]}}, ch}, 1'b1, 1'b0));
        end
        // saturation in both stages
        c = 32'h0;
        c[C_SIGNA] = 1'b1;
        c[C_SIGNB] = 1'b1;
        c[C_SLOAD] = 1'b1;
        c[C_OSAT] = 1'b1;
        c[C_CSAT] = 1'b1;
        a = 32'h1FFFF;
        b = 32'h1FFFF;
        run_op(32'h7FFFFFFF);
        chk({acc, 42'h0, st[S_OVF1]}, {44'h0007FFFFFFF, 42'h0, 1'b1});
        chk({cho, 42'h0, st[S_OVF2]}, {44'h0007FFFFFFF, 42'h0, 1'b1});
        a = 32'h20000;
        run_op(32'h0);
        chk(acc, 44'hFFF80000001);
        c[C_OSAT] = 1'b0;
        c[C_CSAT] = 1'b0;
        run_op(32'h0);
        chk(acc, mul_x(a, b, 1'b1, 1'b1));
        // rounding pushes over the limit, then saturates
        c[C_OSAT] = 1'b1;
        c[C_ORND] = 1'b1;
        a = 32'h8000;
        b = 32'hFFFF;
        run_op(32'h0);
        chk({31'h0, acc[43:31], st[S_OVF1]}, 45'h1);
        // accumulation, zero-load and loopback zeroing
        c = 32'h0;
        c[C_SLOAD] = 1'b1;
        a = rnd32();
        b = rnd32();
        run_op(32'h0);
        p = mul_x(a, b, 1'b0, 1'b0);
        c[C_SLOAD] = 1'b0;
        a = rnd32();
        b = rnd32();
        run_op(32'h0);
        chk(acc, p + mul_x(a, b, 1'b0, 1'b0));
        c[C_ZLOOP] = 1'b1;
        run_op(32'h0);
        p = mul_x(a, b, 1'b0, 1'b0);
        chk(acc, p);
        // update gates and asynchronous clears
        xfer(1'b1, OFF_GATE, 32'hB);
        a = rnd32();
        b = rnd32();
        run_op(32'h0);
        chk(acc, p);
        xfer(1'b1, OFF_CLEAR, 32'hB);
        xfer(1'b0, OFF_ACC_LO, 32'h0);
        chk(44'(rdd), 44'h0);
        xfer(1'b1, OFF_GATE, 32'hF);
        run_op(32'h0);
        chk(acc, 44'h0);
        xfer(1'b1, OFF_CLEAR, 32'hF);
        run_op(32'h0);
        chk(acc, mul_x(a, b, 1'b0, 1'b0));
        print_verdict();
    end
endmodule
`default_nettype wire
